//--- inc/bbrf_pkg.sv
package bbrf_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_HIGH_RATE = 10'h038;
  localparam logic [9:0] IDX_ASSESS_CFG = 10'h03A;
  localparam logic [9:0] IDX_PREAMBLE = 10'h03B;
  localparam logic [9:0] IDX_CARRIER_COUNT = 10'h03C;
  localparam logic [9:0] IDX_STRENGTH_CTRL = 10'h03E;
  localparam logic [9:0] IDX_ENERGY_LEVEL = 10'h03F;
  localparam logic [9:0] IDX_CHANNEL_TRIM = 10'h200;
  localparam logic [9:0] IDX_OSC_TRIM = 10'h201;
  localparam logic [9:0] IDX_SYNTH = 10'h202;
  localparam logic [9:0] IDX_TX_POWER = 10'h203;
  localparam logic [9:0] IDX_BATTERY = 10'h205;
  // field positions (lsb)
  localparam int POS_MODE = 6;
  localparam int POS_CARRIER_TH = 2;
  localparam int POS_PRE_VALID = 4;
  localparam int POS_PRE_DETECT = 1;
  localparam int POS_RX_CARRIER = 5;
  localparam int POS_PRE_COUNT = 2;
  localparam int POS_ONESHOT = 7;
  localparam int POS_PER_PACKET = 6;
  localparam int POS_READY = 0;
  localparam int POS_CHANNEL = 4;
  localparam int POS_RF_TRIM = 0;
  localparam int POS_SYNTH = 7;
  localparam int POS_COARSE = 6;
  localparam int POS_FINE = 3;
  localparam int POS_BATTERY = 4;
  localparam int POS_HIGH_RATE = 0;
  // reset values
  localparam logic [1:0] RST_MODE = 2'h1;
  localparam logic [3:0] RST_CARRIER_TH = 4'h2;
  localparam logic [3:0] RST_PRE_VALID = 4'hD;
  localparam logic [2:0] RST_PRE_DETECT = 3'h4;
  localparam logic [2:0] RST_RX_CARRIER = 3'h4;
  localparam logic [2:0] RST_PRE_COUNT = 3'h7;
  localparam logic [7:0] RST_ENERGY_LEVEL = 8'h00;
  localparam logic RST_READY = 1'b1;
  // channel plan and timing
  localparam logic [11:0] BASE_FREQ_MHZ = 12'h965;
  localparam logic [11:0] CHANNEL_STEP_MHZ = 12'h005;
  localparam logic [4:0] FIRST_CHANNEL = 5'h0B;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MEAS_TIME_NS = 800;
  localparam int MEAS_CYCLES_INT =
    (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MEAS_CYCLES = 8'(MEAS_CYCLES_INT);

  typedef struct packed {
    logic [1:0] assessment_mode;
    logic [3:0] assessment_carrier_threshold;
    logic [3:0] preamble_energy_valid_level;
    logic [2:0] preamble_energy_detect_level;
    logic [2:0] receive_carrier_level;
    logic [2:0] preamble_counter_level;
    logic [7:0] assessment_energy_level;
    logic high_rate;
  } bbrf_baseband_t;

  typedef struct packed {
    logic [3:0] channel;
    logic [3:0] rf_trim;
    logic [7:0] oscillator_trim_value;
    logic synthesiser_enable;
    logic [1:0] coarse_tx_power;
    logic [2:0] fine_tx_power;
    logic [3:0] battery_low_level;
  } bbrf_rf_t;
endpackage

//--- logic/bbrf_regs.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
module bbrf_regs (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CARRIER_DETECT,
  input wire logic [7:0] ENERGY_LEVEL,
  input wire logic PACKET_END,
  output logic CHANNEL_BUSY,
  output logic [7:0] STRENGTH_VALUE,
  output logic [7:0] BUFFER_STRENGTH,
  output logic BUFFER_STRENGTH_VALID,
  output bbrf_pkg::bbrf_baseband_t BB_CONFIG,
  output bbrf_pkg::bbrf_rf_t RF_CONFIG,
  output logic RADIO_PERMIT,
  output logic [4:0] CHANNEL_NUMBER,
  output logic [11:0] CHANNEL_FREQ_MHZ,
  output logic [8:0] TX_ATTEN_TENTHS_DB,
  output logic [11:0] BATTERY_MV,
  output logic BATTERY_LEVEL_VALID
);

  ////////////////////////////////////////////////////////////////////////
  // bus handshake
  logic ack;
  logic req;
  logic wr_en;
  logic [9:0] idx;
  logic [7:0] wd;
  logic [7:0] rd_byte;

  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign idx = AVS_ADDRESS[11:2];
  assign wd = AVS_WRITEDATA[7:0];
  assign wr_en = AVS_WRITE & ack & AVS_BYTEENABLE[0];

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baseband configuration
  logic [1:0] mode;
  logic [3:0] carrier_th;
  logic [3:0] pre_valid;
  logic [2:0] pre_detect;
  logic [2:0] rx_carrier;
  logic [2:0] pre_count;
  logic [7:0] energy_th;
  logic high_rate;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mode <= bbrf_pkg::RST_MODE;
      carrier_th <= bbrf_pkg::RST_CARRIER_TH;
    end else if (wr_en && idx == bbrf_pkg::IDX_ASSESS_CFG) begin
      mode <= wd[bbrf_pkg::POS_MODE +: 2];
      carrier_th <= wd[bbrf_pkg::POS_CARRIER_TH +: 4];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pre_valid <= bbrf_pkg::RST_PRE_VALID;
      pre_detect <= bbrf_pkg::RST_PRE_DETECT;
    end else if (wr_en && idx == bbrf_pkg::IDX_PREAMBLE) begin
      pre_valid <= wd[bbrf_pkg::POS_PRE_VALID +: 4];
      pre_detect <= wd[bbrf_pkg::POS_PRE_DETECT +: 3];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rx_carrier <= bbrf_pkg::RST_RX_CARRIER;
      pre_count <= bbrf_pkg::RST_PRE_COUNT;
    end else if (wr_en && idx == bbrf_pkg::IDX_CARRIER_COUNT) begin
      rx_carrier <= wd[bbrf_pkg::POS_RX_CARRIER +: 3];
      pre_count <= wd[bbrf_pkg::POS_PRE_COUNT +: 3];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      energy_th <= bbrf_pkg::RST_ENERGY_LEVEL;
    end else if (wr_en && idx == bbrf_pkg::IDX_ENERGY_LEVEL) begin
      energy_th <= wd;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      high_rate <= 1'b0;
    end else if (wr_en && idx == bbrf_pkg::IDX_HIGH_RATE) begin
      high_rate <= wd[bbrf_pkg::POS_HIGH_RATE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rf configuration
  logic [3:0] channel;
  logic [3:0] rf_trim;
  logic [7:0] osc_trim;
  logic synth_en;
  logic [1:0] coarse;
  logic [2:0] fine;
  logic [3:0] battery;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      channel <= 4'h0;
      rf_trim <= 4'h0;
    end else if (wr_en && idx == bbrf_pkg::IDX_CHANNEL_TRIM) begin
      channel <= wd[bbrf_pkg::POS_CHANNEL +: 4];
      rf_trim <= wd[bbrf_pkg::POS_RF_TRIM +: 4];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      osc_trim <= 8'h00;
    end else if (wr_en && idx == bbrf_pkg::IDX_OSC_TRIM) begin
      osc_trim <= wd;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      synth_en <= 1'b0;
    end else if (wr_en && idx == bbrf_pkg::IDX_SYNTH) begin
      synth_en <= wd[bbrf_pkg::POS_SYNTH];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      coarse <= 2'h0;
      fine <= 3'h0;
    end else if (wr_en && idx == bbrf_pkg::IDX_TX_POWER) begin
      coarse <= wd[bbrf_pkg::POS_COARSE +: 2];
      fine <= wd[bbrf_pkg::POS_FINE +: 3];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      battery <= 4'h0;
    end else if (wr_en && idx == bbrf_pkg::IDX_BATTERY) begin
      battery <= wd[bbrf_pkg::POS_BATTERY +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // signal strength measurement
  logic oneshot;
  logic per_packet;
  logic ready;
  logic [7:0] meas_cnt;
  logic [7:0] peak;
  logic start;
  logic meas_last;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b01,
    MEAS_RUN = 2'b10
  } bbrf_meas_state_t;

  bbrf_meas_state_t meas_state;
  bbrf_meas_state_t next_meas_state;

  assign start = wr_en && idx == bbrf_pkg::IDX_STRENGTH_CTRL &&
    wd[bbrf_pkg::POS_ONESHOT] && !oneshot;
  assign oneshot = meas_state == MEAS_RUN;
  assign meas_last = meas_cnt == bbrf_pkg::MEAS_CYCLES - 8'h01;

  always_comb begin
    next_meas_state = meas_state;
    unique case (meas_state)
      MEAS_IDLE: begin
        if (start) begin
          next_meas_state = MEAS_RUN;
        end
      end
      MEAS_RUN: begin
        if (meas_last) begin
          next_meas_state = MEAS_IDLE;
        end
      end
      default: next_meas_state = MEAS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      meas_state <= MEAS_IDLE;
    end else begin
      meas_state <= next_meas_state;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ready <= bbrf_pkg::RST_READY;
      meas_cnt <= 8'h00;
      peak <= 8'h00;
      STRENGTH_VALUE <= 8'h00;
    end else if (start) begin
      ready <= 1'b0;
      meas_cnt <= 8'h00;
      peak <= 8'h00;
    end else if (oneshot) begin
      if (ENERGY_LEVEL > peak) begin
        peak <= ENERGY_LEVEL;
      end
      meas_cnt <= meas_cnt + 8'h01;
      if (meas_last) begin
        ready <= 1'b1;
        STRENGTH_VALUE <= (ENERGY_LEVEL > peak) ? ENERGY_LEVEL : peak;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      per_packet <= 1'b0;
    end else if (wr_en && idx == bbrf_pkg::IDX_STRENGTH_CTRL) begin
      per_packet <= wd[bbrf_pkg::POS_PER_PACKET];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      BUFFER_STRENGTH <= 8'h00;
      BUFFER_STRENGTH_VALID <= 1'b0;
    end else begin
      BUFFER_STRENGTH_VALID <= per_packet & PACKET_END & synth_en;
      if (per_packet && PACKET_END && synth_en) begin
        BUFFER_STRENGTH <= ENERGY_LEVEL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // channel assessment
  logic over;
  logic next_busy;

  assign over = ENERGY_LEVEL > energy_th;

  always_comb begin
    unique case (mode)
      2'b11: next_busy = CARRIER_DETECT & over;
      2'b10: next_busy = over;
      2'b01: next_busy = CARRIER_DETECT;
      default: next_busy = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CHANNEL_BUSY <= 1'b0;
    end else begin
      CHANNEL_BUSY <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded rf settings
  logic [8:0] coarse_tenths;
  logic [8:0] fine_tenths;

  always_comb begin
    unique case (coarse)
      2'b00: coarse_tenths = 9'h000;
      2'b01: coarse_tenths = 9'h064;
      2'b10: coarse_tenths = 9'h0C8;
      2'b11: coarse_tenths = 9'h12C;
    endcase
  end

  always_comb begin
    unique case (fine)
      3'h0: fine_tenths = 9'h000;
      3'h1: fine_tenths = 9'h005;
      3'h2: fine_tenths = 9'h00C;
      3'h3: fine_tenths = 9'h013;
      3'h4: fine_tenths = 9'h01C;
      3'h5: fine_tenths = 9'h025;
      3'h6: fine_tenths = 9'h031;
      3'h7: fine_tenths = 9'h03F;
    endcase
  end

  logic [11:0] next_batt_mv;

  always_comb begin
    case (battery)
      4'hE: next_batt_mv = 12'hDAC;
      4'hD: next_batt_mv = 12'hCE4;
      4'hC: next_batt_mv = 12'hC80;
      4'hB: next_batt_mv = 12'hC1C;
      4'hA: next_batt_mv = 12'hAF0;
      4'h9: next_batt_mv = 12'hA8C;
      4'h8: next_batt_mv = 12'hA28;
      4'h7: next_batt_mv = 12'h9C4;
      default: next_batt_mv = 12'h000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      TX_ATTEN_TENTHS_DB <= 9'h000;
      CHANNEL_FREQ_MHZ <= bbrf_pkg::BASE_FREQ_MHZ;
      CHANNEL_NUMBER <= bbrf_pkg::FIRST_CHANNEL;
      BATTERY_MV <= 12'h000;
      BATTERY_LEVEL_VALID <= 1'b0;
    end else begin
      TX_ATTEN_TENTHS_DB <= coarse_tenths + fine_tenths;
      CHANNEL_FREQ_MHZ <= bbrf_pkg::BASE_FREQ_MHZ +
        12'({8'h00, channel} * bbrf_pkg::CHANNEL_STEP_MHZ);
      CHANNEL_NUMBER <= bbrf_pkg::FIRST_CHANNEL + {1'b0, channel};
      BATTERY_MV <= next_batt_mv;
      BATTERY_LEVEL_VALID <= next_batt_mv != 12'h000;
    end
  end

  assign RADIO_PERMIT = synth_en;

  assign BB_CONFIG = '{
    assessment_mode: mode,
    assessment_carrier_threshold: carrier_th,
    preamble_energy_valid_level: pre_valid,
    preamble_energy_detect_level: pre_detect,
    receive_carrier_level: rx_carrier,
    preamble_counter_level: pre_count,
    assessment_energy_level: energy_th,
    high_rate: high_rate};

  assign RF_CONFIG = '{
    channel: channel,
    rf_trim: rf_trim,
    oscillator_trim_value: osc_trim,
    synthesiser_enable: synth_en,
    coarse_tx_power: coarse,
    fine_tx_power: fine,
    battery_low_level: battery};

  ////////////////////////////////////////////////////////////////////////
  // read path; reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      bbrf_pkg::IDX_HIGH_RATE: rd_byte = {7'h00, high_rate};
      bbrf_pkg::IDX_ASSESS_CFG: rd_byte = {mode, carrier_th, 2'h0};
      bbrf_pkg::IDX_PREAMBLE: rd_byte = {pre_valid, pre_detect, 1'b0};
      bbrf_pkg::IDX_CARRIER_COUNT: rd_byte = {rx_carrier, pre_count, 2'h0};
      bbrf_pkg::IDX_STRENGTH_CTRL:
        rd_byte = {oneshot, per_packet, 5'h00, ready};
      bbrf_pkg::IDX_ENERGY_LEVEL: rd_byte = energy_th;
      bbrf_pkg::IDX_CHANNEL_TRIM: rd_byte = {channel, rf_trim};
      bbrf_pkg::IDX_OSC_TRIM: rd_byte = osc_trim;
      bbrf_pkg::IDX_SYNTH: rd_byte = {synth_en, 7'h00};
      bbrf_pkg::IDX_TX_POWER: rd_byte = {coarse, fine, 3'h0};
      bbrf_pkg::IDX_BATTERY: rd_byte = {battery, 4'h0};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack) begin
      AVS_READDATA <= {24'h00_0000, rd_byte};
    end
  end

endmodule

//--- tb/bbrf_regs_sva.sv
`timescale 1ns/1ps
module bbrf_regs_sva (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic CARRIER_DETECT,
  input wire logic [7:0] ENERGY_LEVEL,
  input wire logic PACKET_END,
  input wire logic CHANNEL_BUSY,
  input wire logic [7:0] BUFFER_STRENGTH,
  input wire logic BUFFER_STRENGTH_VALID,
  input wire bbrf_pkg::bbrf_baseband_t BB_CONFIG,
  input wire bbrf_pkg::bbrf_rf_t RF_CONFIG,
  input wire logic RADIO_PERMIT,
  input wire logic [4:0] CHANNEL_NUMBER,
  input wire logic [11:0] CHANNEL_FREQ_MHZ,
  input wire logic [8:0] TX_ATTEN_TENTHS_DB,
  input wire logic [11:0] BATTERY_MV,
  input wire logic BATTERY_LEVEL_VALID
);
  // fine attenuation in tenths of a db, code 0 lowest
  localparam logic [71:0] FINE_TAB = {9'h03F, 9'h031, 9'h025, 9'h01C,
    9'h013, 9'h00C, 9'h005, 9'h000};
  // battery threshold in mv, code 0 lowest
  localparam logic [191:0] BAT_TAB = {12'h000, 12'hDAC, 12'hCE4, 12'hC80,
    12'hC1C, 12'hAF0, 12'hA8C, 12'hA28, 12'h9C4, 84'h0};
  wire logic [1:0] mode = BB_CONFIG.assessment_mode;
  wire logic hot = ENERGY_LEVEL > BB_CONFIG.assessment_energy_level;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  //////////////////////////////////////////////////////////////////////
  sequence s_status_read;
    AVS_READ && !AVS_WAITREQUEST
      && AVS_ADDRESS[11:2] == bbrf_pkg::IDX_STRENGTH_CTRL;
  endsequence
  sequence s_blocked_packet;
    PACKET_END && !RADIO_PERMIT;
  endsequence
  property p_busy_both;
    mode == 2'h3 |=> CHANNEL_BUSY == ($past(CARRIER_DETECT) && $past(hot));
  endproperty
  property p_busy_energy;
    mode == 2'h2 |=> CHANNEL_BUSY == $past(hot);
  endproperty
  property p_busy_carrier;
    mode == 2'h1 |=> CHANNEL_BUSY == $past(CARRIER_DETECT);
  endproperty
  property p_busy_reserved;
    mode == 2'h0 |=> !CHANNEL_BUSY;
  endproperty
  property p_status;
    s_status_read |-> AVS_READDATA[7] != AVS_READDATA[0]
      && AVS_READDATA[5:1] == 5'h00 && AVS_READDATA[31:8] == 24'h000000;
  endproperty
  property p_pkt_gate;
    s_blocked_packet |=> !BUFFER_STRENGTH_VALID;
  endproperty
  property p_pkt_data;
    BUFFER_STRENGTH_VALID |-> $past(PACKET_END) && $past(RADIO_PERMIT)
      && BUFFER_STRENGTH == $past(ENERGY_LEVEL);
  endproperty
  property p_channel;
    CHANNEL_NUMBER == 5'h0B + 5'($past(RF_CONFIG.channel))
      && CHANNEL_FREQ_MHZ == 12'h965 + 12'h005 * 12'($past(RF_CONFIG.channel));
  endproperty
  property p_power;
    TX_ATTEN_TENTHS_DB == 9'h064 * 9'($past(RF_CONFIG.coarse_tx_power))
      + FINE_TAB[$past(RF_CONFIG.fine_tx_power) * 9 +: 9];
  endproperty
  property p_battery;
    BATTERY_MV == BAT_TAB[$past(RF_CONFIG.battery_low_level) * 12 +: 12]
      && BATTERY_LEVEL_VALID
        == ($past(RF_CONFIG.battery_low_level) inside {[4'h7:4'hE]});
  endproperty
  //////////////////////////////////////////////////////////////////////
  a_busy_both: assert property (p_busy_both)
    else $error("busy wrong in carrier with energy mode");
  a_busy_energy: assert property (p_busy_energy)
    else $error("busy wrong in energy mode");
  a_busy_carrier: assert property (p_busy_carrier)
    else $error("busy wrong in carrier mode");
  a_busy_reserved: assert property (p_busy_reserved)
    else $error("busy raised in reserved mode");
  a_status: assert property (p_status)
    else $error("start bit and ready flag inconsistent");
  a_pkt_gate: assert property (p_pkt_gate)
    else $error("packet strength stored with synthesiser off");
  a_pkt_data: assert property (p_pkt_data)
    else $error("packet strength wrong");
  a_channel: assert property (p_channel)
    else $error("channel number or frequency wrong");
  a_power: assert property (p_power)
    else $error("transmit attenuation wrong");
  a_battery: assert property (p_battery)
    else $error("battery threshold wrong");
endmodule

bind bbrf_regs bbrf_regs_sva i_bbrf_regs_sva (
  .CLK_SYS, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_READDATA, .AVS_WAITREQUEST,
  .CARRIER_DETECT, .ENERGY_LEVEL, .PACKET_END, .CHANNEL_BUSY,
  .BUFFER_STRENGTH, .BUFFER_STRENGTH_VALID, .BB_CONFIG, .RF_CONFIG,
  .RADIO_PERMIT, .CHANNEL_NUMBER, .CHANNEL_FREQ_MHZ, .TX_ATTEN_TENTHS_DB,
  .BATTERY_MV, .BATTERY_LEVEL_VALID
);

//--- tb/bbrf_regs_tb.sv
`timescale 1ns/1ps
module bbrf_regs_tb;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic [11:0] AVS_ADDRESS = 12'h000;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic CARRIER_DETECT = 1'b0;
  logic [7:0] ENERGY_LEVEL = 8'h00;
  logic PACKET_END = 1'b0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [7:0] STRENGTH_VALUE;
  int bad_count = 0;
  int checks_done = 0;
  bit rnd_on = 1'b1;
  logic [31:0] exp_q[$];
  logic [9:0] idx_t [11] = '{10'h038, 10'h03A, 10'h03B, 10'h03C, 10'h03F,
    10'h200, 10'h201, 10'h202, 10'h203, 10'h205, 10'h03E};
  logic [7:0] rst_t [11] = '{8'h00, 8'h48, 8'hD8, 8'h9C, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] msk_t [10] = '{8'h01, 8'hFC, 8'hFE, 8'hFC, 8'hFF, 8'hFF,
    8'hFF, 8'h80, 8'hF8, 8'hF0};
  logic [7:0] rec_t [8] = '{8'h01, 8'hF8, 8'h38, 8'h5C, 8'h60, 8'h03,
    8'h02, 8'h80};

  bbrf_regs i_bbrf_regs (
    .CLK_SYS, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .CARRIER_DETECT,
    .ENERGY_LEVEL, .PACKET_END, .CHANNEL_BUSY(), .STRENGTH_VALUE,
    .BUFFER_STRENGTH(), .BUFFER_STRENGTH_VALID(), .BB_CONFIG(),
    .RF_CONFIG(), .RADIO_PERMIT(), .CHANNEL_NUMBER(), .CHANNEL_FREQ_MHZ(),
    .TX_ATTEN_TENTHS_DB(), .BATTERY_MV(), .BATTERY_LEVEL_VALID()
  );

  initial begin
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [9:0] idx,
      input logic [7:0] d, input logic [3:0] be);
    int n = 0;
    AVS_ADDRESS <= {idx, 2'h0};
    AVS_WRITEDATA <= {24'h000000, d};
    AVS_BYTEENABLE <= be;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (n >= 20) begin
      bad_count++;
      finish_test();
    end
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLK_SYS);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(1'b0, idx, 8'h00, 4'hF);
  endtask

  task automatic do_reset();
    RESET <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
  endtask

  task automatic chk_reset();
    for (int i = 0; i < 11; i++) begin
      rd(idx_t[i], rst_t[i]);
    end
    rd(10'h100, 8'h00);
  endtask
  //////////////////////////////////////////////////////////////////////
  // read results are compared against the oldest noted expectation
  always @(posedge CLK_SYS) begin
    if (AVS_READ && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0) begin
      chk(AVS_READDATA, exp_q.pop_front());
    end
  end

  // modem side traffic
  always @(posedge CLK_SYS) begin
    PACKET_END <= ($urandom_range(3) == 0);
    if (rnd_on) begin
      CARRIER_DETECT <= 1'($urandom);
      ENERGY_LEVEL <= 8'($urandom);
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    void'($urandom(32'h8392E3E1));
    do_reset();
    chk_reset();
    // sixteen codes per register except strength control, masked byte and unmapped writes ignored
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 16; k++) begin
        d = {4'(k), 3'(k >> 1), 1'($urandom)} & msk_t[i];
        wr(idx_t[i], d);
        bus(1'b1, idx_t[i], ~d & msk_t[i], 4'hE);
        bus(1'b1, 10'h100, ~d, 4'hF);
        rd(idx_t[i], d & msk_t[i]);
      end
    end
    // recommended settings for high rate operation
    for (int i = 0; i < 8; i++) begin
      wr(idx_t[i], rec_t[i]);
      rd(idx_t[i], rec_t[i]);
    end
    // one-shot measurement with per-packet storage enabled
    rnd_on = 1'b0;
    @(posedge CLK_SYS);
    v = 8'($urandom);
    ENERGY_LEVEL <= v;
    wr(10'h03E, 8'hC0);
    rd(10'h03E, 8'hC0);
    repeat (8) @(posedge CLK_SYS);
    rd(10'h03E, 8'h41);
    chk({24'h000000, STRENGTH_VALUE}, {24'h000000, v});
    rnd_on = 1'b1;
    do_reset();
    chk_reset();
    finish_test();
  end
endmodule
